/* File: src/sdram_host_ctrl.sv */
// Controller that initialises and drives a four-bank synchronous memory from software registers.
//
// How it works
// - After power-up wait 100 us, then two auto refreshes before any access.
// - When refresh interval is overrun, repeat two auto refreshes first.
// - Keep the clock constant during accesses; clock gate may lower data rate.
// - Clock keeps toggling through the whole self-refresh exit wait.
// - Write recovery is one cycle only at 10 ns period or slower.
// - Access begins with activate carrying bank and row on A[10:0].
// - Inhibit, nop, activate, read, write use the listed strobe patterns.
// - Burst stop, precharge, refresh and mode load use the listed patterns.
// - Clock gate high except self refresh; refresh with gate low enters it.
// - Spread accesses across rows; repeated hits on one row wear the part. The code does not spread them; it only counts repeats in REG_HOTROW.
// - Wait at least two cycles after mode load before activate or refresh.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module sdram_host_ctrl #(
  parameter int INIT_WAIT_CYCLES = sdram_host_pkg::INIT_WAIT_CYC
) (
  input wire logic clk, // System clock, 200 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  output logic [31:0] reg_rdata, // Read data, valid the cycle after the strobe.
  output logic clock_gate, // Memory clock enable.
  output logic select_n, // Memory chip select, active low.
  output logic row_strobe_n, // Row strobe, active low.
  output logic col_strobe_n, // Column strobe, active low.
  output logic write_strobe_n, // Write strobe, active low.
  output logic bank_select_low, // Bank select bit 0.
  output logic bank_select_high, // Bank select bit 1.
  output logic [11:0] mem_addr, // Memory address pins.
  output logic [3:0] byte_mask, // Byte mask pins, high blocks a byte.
  input wire logic [31:0] dq_in, // Data pins as seen from outside.
  output logic [31:0] dq_out, // Data driven onto the pins.
  output logic dq_oe_n // Data pin drive enable, low while driving.
);

  typedef enum logic [3:0] {
    S_POWERUP = 4'h0,
    S_INIT_PRE = 4'h1,
    S_REFRESH = 4'h2,
    S_INIT_MODE = 4'h3,
    S_IDLE = 4'h4,
    S_ACCESS = 4'h5,
    S_CAPTURE = 4'h6,
    S_WAIT = 4'h7,
    S_SELF_REF = 4'h8
  } state_e;

  state_e state_q;
  state_e ret_q;
  logic timer_load;
  logic [15:0] timer_value;
  logic timer_expired;
  logic [31:0] dq_sync;

  logic [3:0] cmd_q;
  logic cke_q;
  logic [1:0] bank_q;
  logic [11:0] addr_pin_q;
  logic [3:0] mask_pin_q;
  logic [31:0] dq_out_q;
  logic oe_n_q;
  logic [31:0] reg_rdata_q;

  logic [11:0] mode_q;
  logic [3:0] mask_q;
  logic [20:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_buf_q;
  logic rdata_valid_q;
  logic op_pend_q;
  logic [2:0] op_q;
  logic autopre_q;
  logic allbank_q;
  logic init_done_q;
  logic [1:0] ref_left_q;
  logic [11:0] refi_cnt_q;
  logic ref_pending_q;
  logic wake_q;
  logic [12:0] last_row_q;
  logic [15:0] hotrow_q;
  logic op_take;
  logic capture;
  logic refi_tick;

  sdram_wait_timer #(.W(sdram_host_pkg::TIMER_W)) u_timer (
    .clk(clk),
    .reset(reset),
    .load(timer_load),
    .value(timer_value),
    .expired(timer_expired)
  );

  sdram_pin_sync #(.W(sdram_host_pkg::DATA_W)) u_dq_sync (
    .clk(clk),
    .reset(reset),
    .d(dq_in),
    .q(dq_sync)
  );

  assign select_n = cmd_q[3];
  assign row_strobe_n = cmd_q[2];
  assign col_strobe_n = cmd_q[1];
  assign write_strobe_n = cmd_q[0];
  assign clock_gate = cke_q;
  assign bank_select_low = bank_q[0];
  assign bank_select_high = bank_q[1];
  assign mem_addr = addr_pin_q;
  assign byte_mask = mask_pin_q;
  assign dq_out = dq_out_q;
  assign dq_oe_n = oe_n_q;
  assign reg_rdata = reg_rdata_q;

  // An order is taken only when the sequencer can act on it right away or from self refresh.
  assign op_take = op_pend_q && ((state_q == S_IDLE && !ref_pending_q) ||
                   (state_q == S_SELF_REF && op_q == sdram_host_pkg::OP_SREF_EXIT));
  assign capture = (state_q == S_CAPTURE);
  assign refi_tick = (refi_cnt_q == 12'(sdram_host_pkg::TREFI_CYC - 1));

  // Wait length for the command issued in this cycle.
  always_comb begin
    timer_load = 1'b0;
    timer_value = 16'h0001;
    case (state_q)
      S_POWERUP: begin
        timer_load = 1'b1;
        timer_value = 16'(INIT_WAIT_CYCLES);
      end
      S_INIT_PRE: begin
        timer_load = 1'b1;
        timer_value = 16'(sdram_host_pkg::TRP_CYC);
      end
      S_REFRESH: begin
        timer_load = 1'b1;
        timer_value = 16'(sdram_host_pkg::TRFC_CYC);
      end
      S_INIT_MODE: begin
        timer_load = 1'b1;
        timer_value = 16'(sdram_host_pkg::MODE_LOAD_DELAY_CYC);
      end
      S_IDLE, S_SELF_REF: begin
        timer_load = op_take;
        if (op_q == sdram_host_pkg::OP_READ || op_q == sdram_host_pkg::OP_WRITE) begin
          timer_value = 16'(sdram_host_pkg::TRCD_CYC);
        end else if (op_q == sdram_host_pkg::OP_PRECHARGE) begin
          timer_value = 16'(sdram_host_pkg::TRP_CYC);
        end else if (op_q == sdram_host_pkg::OP_MODE_LOAD) begin
          timer_value = 16'(sdram_host_pkg::MODE_LOAD_DELAY_CYC);
        end else if (op_q == sdram_host_pkg::OP_SREF_EXIT) begin
          timer_value = 16'(sdram_host_pkg::SELF_REFRESH_EXIT_CYC);
        end else begin
          timer_value = 16'h0001;
        end
      end
      S_ACCESS: begin
        timer_load = 1'b1;
        if (op_q == sdram_host_pkg::OP_READ) begin
          timer_value = 16'(sdram_host_pkg::READ_WAIT_CYC - 2); // Exit and capture edges.
        end else if (autopre_q) begin
          timer_value = 16'(sdram_host_pkg::WR_RECOVERY_CYC + sdram_host_pkg::TRP_CYC);
        end else begin
          timer_value = 16'(sdram_host_pkg::WR_RECOVERY_CYC);
        end
      end
      S_CAPTURE: begin
        timer_load = 1'b1;
        timer_value = 16'(sdram_host_pkg::TRP_CYC);
      end
      default: begin
        timer_load = 1'b0;
        timer_value = 16'h0001;
      end
    endcase
  end

  // Command sequencer and pin drive.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= S_POWERUP;
      ret_q <= S_IDLE;
      cmd_q <= sdram_host_pkg::CMD_INHIBIT;
      cke_q <= 1'b1;
      bank_q <= 2'h0;
      addr_pin_q <= 12'h000;
      mask_pin_q <= 4'hf;
      dq_out_q <= 32'h00000000;
      oe_n_q <= 1'b1;
      ref_left_q <= 2'h0;
      init_done_q <= 1'b0;
    end else begin
      cmd_q <= sdram_host_pkg::CMD_INHIBIT;
      oe_n_q <= 1'b1;
      cke_q <= 1'b1;
      case (state_q)
        S_POWERUP: begin
          cmd_q <= sdram_host_pkg::CMD_NOP;
          state_q <= S_WAIT;
          ret_q <= S_INIT_PRE;
        end
        S_INIT_PRE: begin
          cmd_q <= sdram_host_pkg::CMD_PRECHARGE;
          addr_pin_q[sdram_host_pkg::PRECHARGE_FLAG_POS] <= 1'b1;
          ref_left_q <= 2'(sdram_host_pkg::INIT_REFRESH_COUNT);
          state_q <= S_WAIT;
          ret_q <= S_REFRESH;
        end
        S_REFRESH: begin
          cmd_q <= sdram_host_pkg::CMD_REFRESH;
          ref_left_q <= ref_left_q - 2'h1;
          state_q <= S_WAIT;
          if (ref_left_q > 2'h1) begin
            ret_q <= S_REFRESH;
          end else if (init_done_q) begin
            ret_q <= S_IDLE;
          end else begin
            ret_q <= S_INIT_MODE;
          end
        end
        S_INIT_MODE: begin
          cmd_q <= sdram_host_pkg::CMD_MODE_LOAD;
          addr_pin_q <= mode_q;
          bank_q <= 2'h0;
          init_done_q <= 1'b1;
          state_q <= S_WAIT;
          ret_q <= S_IDLE;
        end
        S_IDLE: begin
          if (ref_pending_q) begin
            ref_left_q <= wake_q ? 2'(sdram_host_pkg::INIT_REFRESH_COUNT) : 2'h1;
            state_q <= S_REFRESH;
          end else if (op_take) begin
            state_q <= S_WAIT;
            ret_q <= S_IDLE;
            case (op_q)
              sdram_host_pkg::OP_READ, sdram_host_pkg::OP_WRITE: begin
                cmd_q <= sdram_host_pkg::CMD_ACTIVATE;
                bank_q <= addr_q[sdram_host_pkg::ADDR_BANK_LSB +: 2];
                addr_pin_q <= {1'b0, addr_q[sdram_host_pkg::ADDR_ROW_LSB +: 11]};
                ret_q <= S_ACCESS;
              end
              sdram_host_pkg::OP_PRECHARGE: begin
                cmd_q <= sdram_host_pkg::CMD_PRECHARGE;
                bank_q <= addr_q[sdram_host_pkg::ADDR_BANK_LSB +: 2];
                addr_pin_q <= 12'h000;
                addr_pin_q[sdram_host_pkg::PRECHARGE_FLAG_POS] <= allbank_q;
              end
              sdram_host_pkg::OP_REFRESH: begin
                ref_left_q <= 2'h1;
                state_q <= S_REFRESH;
              end
              sdram_host_pkg::OP_SREF_ENTER: begin
                cmd_q <= sdram_host_pkg::CMD_REFRESH;
                cke_q <= 1'b0;
                state_q <= S_SELF_REF;
              end
              sdram_host_pkg::OP_BURST_STOP: begin
                cmd_q <= sdram_host_pkg::CMD_BURST_STOP;
              end
              sdram_host_pkg::OP_MODE_LOAD: begin
                cmd_q <= sdram_host_pkg::CMD_MODE_LOAD;
                bank_q <= 2'h0;
                addr_pin_q <= mode_q;
              end
              default: begin
                state_q <= S_IDLE;
              end
            endcase
          end
        end
        S_ACCESS: begin
          bank_q <= addr_q[sdram_host_pkg::ADDR_BANK_LSB +: 2];
          addr_pin_q <= 12'h000;
          addr_pin_q[sdram_host_pkg::COL_W-1:0] <= addr_q[sdram_host_pkg::ADDR_COL_LSB +: 8];
          addr_pin_q[sdram_host_pkg::PRECHARGE_FLAG_POS] <= autopre_q;
          mask_pin_q <= mask_q;
          state_q <= S_WAIT;
          if (op_q == sdram_host_pkg::OP_READ) begin
            cmd_q <= sdram_host_pkg::CMD_READ;
            ret_q <= S_CAPTURE;
          end else begin
            cmd_q <= sdram_host_pkg::CMD_WRITE;
            dq_out_q <= wdata_q;
            oe_n_q <= 1'b0;
            ret_q <= S_IDLE;
          end
        end
        S_CAPTURE: begin
          mask_pin_q <= 4'hf;
          state_q <= S_WAIT;
          ret_q <= S_IDLE;
        end
        S_SELF_REF: begin
          cke_q <= 1'b0;
          if (op_take) begin
            cke_q <= 1'b1;
            cmd_q <= sdram_host_pkg::CMD_NOP;
            state_q <= S_WAIT;
            ret_q <= S_IDLE;
          end
        end
        S_WAIT: begin
          if (timer_expired) begin
            state_q <= ret_q;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Refresh interval timer; a tick while one is still owed means the interval was overrun.
  always_ff @(posedge clk) begin
    if (reset) begin
      refi_cnt_q <= 12'h000;
      ref_pending_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      if (state_q == S_SELF_REF || !init_done_q) begin
        refi_cnt_q <= 12'h000;
      end else if (refi_tick) begin
        refi_cnt_q <= 12'h000;
      end else begin
        refi_cnt_q <= refi_cnt_q + 12'h001;
      end
      if (state_q == S_IDLE && ref_pending_q) begin
        ref_pending_q <= refi_tick;
        wake_q <= 1'b0;
      end else if (refi_tick && state_q != S_SELF_REF && init_done_q) begin
        ref_pending_q <= 1'b1;
        if (ref_pending_q) begin
          wake_q <= 1'b1;
        end
      end
    end
  end

  // Software registers and pending order.
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= sdram_host_pkg::MODE_RESET;
      mask_q <= sdram_host_pkg::MASK_RESET;
      addr_q <= sdram_host_pkg::ADDR_RESET;
      wdata_q <= 32'h00000000;
      op_pend_q <= 1'b0;
      op_q <= 3'h0;
      autopre_q <= 1'b0;
      allbank_q <= 1'b0;
    end else begin
      if (op_take) begin
        op_pend_q <= 1'b0;
      end
      if (reg_wr && !op_pend_q) begin
        if (reg_addr == sdram_host_pkg::REG_CTRL) begin
          op_pend_q <= 1'b1;
          op_q <= reg_wdata[sdram_host_pkg::CTRL_OP_LSB +: 3];
          autopre_q <= reg_wdata[sdram_host_pkg::CTRL_AUTOPRE_BIT];
          allbank_q <= reg_wdata[sdram_host_pkg::CTRL_ALLBANK_BIT];
        end else if (reg_addr == sdram_host_pkg::REG_ADDR) begin
          addr_q <= reg_wdata[20:0];
        end else if (reg_addr == sdram_host_pkg::REG_WDATA) begin
          wdata_q <= reg_wdata;
        end else if (reg_addr == sdram_host_pkg::REG_MODE) begin
          mode_q <= reg_wdata[11:0];
        end else if (reg_addr == sdram_host_pkg::REG_MASK) begin
          mask_q <= reg_wdata[3:0];
        end
      end
    end
  end

  // Read capture, repeated-row counter and register read port.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_buf_q <= 32'h00000000;
      rdata_valid_q <= 1'b0;
      last_row_q <= 13'h0000;
      hotrow_q <= 16'h0000;
      reg_rdata_q <= 32'h00000000;
    end else begin
      if (capture) begin
        rdata_buf_q <= dq_sync;
        rdata_valid_q <= 1'b1;
      end else if (reg_rd && reg_addr == sdram_host_pkg::REG_RDATA) begin
        rdata_valid_q <= 1'b0;
      end
      if (state_q == S_IDLE && op_take && !ref_pending_q &&
          (op_q == sdram_host_pkg::OP_READ || op_q == sdram_host_pkg::OP_WRITE)) begin
        last_row_q <= addr_q[sdram_host_pkg::ADDR_ROW_LSB +: 13];
        if (addr_q[sdram_host_pkg::ADDR_ROW_LSB +: 13] == last_row_q) begin
          if (hotrow_q != 16'hffff) begin
            hotrow_q <= hotrow_q + 16'h0001;
          end
        end else begin
          hotrow_q <= 16'h0000;
        end
      end
      reg_rdata_q <= 32'h00000000;
      if (reg_rd) begin
        if (reg_addr == sdram_host_pkg::REG_CTRL) begin
          reg_rdata_q[sdram_host_pkg::ST_BUSY] <= op_pend_q || (state_q != S_IDLE);
          reg_rdata_q[sdram_host_pkg::ST_INIT_DONE] <= init_done_q;
          reg_rdata_q[sdram_host_pkg::ST_SELF_REF] <= (state_q == S_SELF_REF);
          reg_rdata_q[sdram_host_pkg::ST_RDATA_VALID] <= rdata_valid_q;
          reg_rdata_q[sdram_host_pkg::ST_WAKE] <= wake_q;
        end else if (reg_addr == sdram_host_pkg::REG_ADDR) begin
          reg_rdata_q <= {11'h000, addr_q};
        end else if (reg_addr == sdram_host_pkg::REG_WDATA) begin
          reg_rdata_q <= wdata_q;
        end else if (reg_addr == sdram_host_pkg::REG_RDATA) begin
          reg_rdata_q <= rdata_buf_q;
        end else if (reg_addr == sdram_host_pkg::REG_MODE) begin
          reg_rdata_q <= {20'h00000, mode_q};
        end else if (reg_addr == sdram_host_pkg::REG_MASK) begin
          reg_rdata_q <= {28'h0000000, mask_q};
        end else if (reg_addr == sdram_host_pkg::REG_HOTROW) begin
          reg_rdata_q <= {16'h0000, hotrow_q};
        end
      end
    end
  end

endmodule : sdram_host_ctrl

/* File: src/sdram_host_pkg.sv */
// Constants, register map and command codes of the memory command controller.
package sdram_host_pkg;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int DATA_W = 32;
  localparam int DQM_W = 4;
  localparam int MEM_ADDR_W = 12;
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int BANK_W = 2;
  localparam int TIMER_W = 16;
  localparam int PRECHARGE_FLAG_POS = 10;

  // Minimum times round up to cycles; the refresh interval rounds down.
  localparam int INIT_WAIT_US = 100;
  localparam int INIT_WAIT_CYC = (INIT_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRCD_PS = 15000;
  localparam int TRCD_CYC = (TRCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRP_PS = 15000;
  localparam int TRP_CYC = (TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRFC_PS = 60000;
  localparam int TRFC_CYC = (TRFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SELF_REFRESH_EXIT_TIME_PS = 55000;
  localparam int SELF_REFRESH_EXIT_CYC =
    (SELF_REFRESH_EXIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TREFI_NS = 15625;
  localparam int TREFI_CYC = TREFI_NS * 1000 / CLK_PERIOD_PS;
  localparam int MODE_LOAD_DELAY_CYC = 2;
  localparam int WR_RECOVERY_CYC = (CLK_PERIOD_PS >= 10000) ? 1 : 2;
  localparam int CAS_LATENCY_CYC = 3;
  localparam int SYNC_STAGES = 2;
  localparam int READ_WAIT_CYC = CAS_LATENCY_CYC + SYNC_STAGES + 1;
  localparam int INIT_REFRESH_COUNT = 2;

  // Pin pattern {select_n, row_strobe_n, col_strobe_n, write_strobe_n}.
  localparam logic [3:0] CMD_INHIBIT = 4'hf;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_BURST_STOP = 4'h6;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_MODE_LOAD = 4'h0;

  // Software register map (byte offsets).
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_MODE = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_HOTROW = 8'h18;

  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_AUTOPRE_BIT = 3;
  localparam int CTRL_ALLBANK_BIT = 4;
  localparam int ADDR_COL_LSB = 0;
  localparam int ADDR_ROW_LSB = 8;
  localparam int ADDR_BANK_LSB = 19;
  localparam int ST_BUSY = 0;
  localparam int ST_INIT_DONE = 1;
  localparam int ST_SELF_REF = 2;
  localparam int ST_RDATA_VALID = 3;
  localparam int ST_WAKE = 4;

  localparam logic [11:0] MODE_RESET = 12'h030;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [20:0] ADDR_RESET = 21'h000000;

  typedef enum logic [2:0] {
    OP_MODE_LOAD = 3'h0,
    OP_READ = 3'h1,
    OP_WRITE = 3'h2,
    OP_PRECHARGE = 3'h3,
    OP_REFRESH = 3'h4,
    OP_SREF_ENTER = 3'h5,
    OP_SREF_EXIT = 3'h6,
    OP_BURST_STOP = 3'h7
  } op_e;

endpackage : sdram_host_pkg

/* File: src/sdram_pin_sync.sv */
// Two flip-flop synchroniser for inputs arriving from the pins.
`timescale 1ns/100ps
module sdram_pin_sync #(
  parameter int W = 32
) (
  input wire logic clk, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic [W-1:0] d, // Raw pin level.
  output logic [W-1:0] q // Level after two stages.
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule : sdram_pin_sync

/* File: src/sdram_wait_timer.sv */
// Down counter that times the gap between memory commands.
`timescale 1ns/100ps
module sdram_wait_timer #(
  parameter int W = 16
) (
  input wire logic clk, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic load, // Start a new wait.
  input wire logic [W-1:0] value, // Cycles to wait.
  output logic expired // Count has reached zero.
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign expired = (cnt_q == '0);

endmodule : sdram_wait_timer

/* File: verification/sdram_command_interface_tb.sv */
// Self-checking bench for the memory command controller.
`timescale 1ns/100ps
module sdram_command_interface_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, dq_in, dq_out, dq_mem, got;
  logic clock_gate, select_n, row_strobe_n, col_strobe_n, write_strobe_n, bsl, bsh, dq_oe_n;
  logic [11:0] mem_addr;
  logic [3:0] byte_mask;
  int err_count = 0;
  int checks = 0;
  int n;
  assign dq_in = dq_oe_n ? dq_mem : dq_out;
  sdram_host_ctrl #(.INIT_WAIT_CYCLES(20)) sdram_host_ctrl_i (.clk, .reset, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .clock_gate, .select_n, .row_strobe_n,
    .col_strobe_n, .write_strobe_n, .bank_select_low(bsl), .bank_select_high(bsh), .mem_addr,
    .byte_mask, .dq_in, .dq_out, .dq_oe_n);
  sdram_mem_model sdram_mem_model_i (.clk, .clock_gate, .select_n, .row_strobe_n, .col_strobe_n,
    .write_strobe_n, .bank_select_low(bsl), .bank_select_high(bsh), .mem_addr, .byte_mask, .dq_in,
    .dq(dq_mem));
  initial forever #2.5 clk = ~clk;
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask : rd
  task automatic order(input logic [31:0] c);
    wr(sdram_host_pkg::REG_CTRL, c);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 300; i++) begin
      rd(sdram_host_pkg::REG_CTRL);
      if (got[0] === 1'b0 || got[2] === 1'b1) break;
    end
    check("order done", got[0] & !got[2], 0);
  endtask : order
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 400 && got[1] !== 1'b1; i++) rd(sdram_host_pkg::REG_CTRL);
    check("init refreshes", sdram_mem_model_i.ref_cnt, 2);
    check("init mode", sdram_mem_model_i.mode_q, 12'h030);
    $display("init done");
    wr(sdram_host_pkg::REG_ADDR, {11'h0, 2'h2, 11'h5a5, 8'h3c});
    wr(sdram_host_pkg::REG_WDATA, 32'h12345678);
    wr(sdram_host_pkg::REG_MASK, 32'h0);
    order(32'h2);
    wr(sdram_host_pkg::REG_WDATA, 32'hcafef00d);
    wr(sdram_host_pkg::REG_MASK, 32'h3);
    order(32'h2);
    wr(sdram_host_pkg::REG_MASK, 32'h0);
    order(32'h9);
    rd(sdram_host_pkg::REG_RDATA);
    check("read data", got, 32'hcafe5678);
    check("autopre closed", sdram_mem_model_i.open_q, 4'h0);
    rd(sdram_host_pkg::REG_HOTROW);
    check("hot row", got, 2);
    $display("access done");
    wr(sdram_host_pkg::REG_ADDR, {11'h0, 2'h0, 11'h001, 8'h00});
    order(32'h2);
    wr(sdram_host_pkg::REG_ADDR, {11'h0, 2'h1, 11'h7ff, 8'hff});
    order(32'h2);
    check("two rows open", sdram_mem_model_i.open_q, 4'h3);
    order(32'h3);
    check("one bank closed", sdram_mem_model_i.open_q, 4'h1);
    order(32'h13);
    check("all banks closed", sdram_mem_model_i.open_q, 4'h0);
    $display("precharge done");
    wr(sdram_host_pkg::REG_MODE, 32'h230);
    order(32'h0);
    check("mode load", sdram_mem_model_i.mode_q, 12'h230);
    n = sdram_mem_model_i.ref_cnt;
    order(32'h4);
    check("auto refresh", sdram_mem_model_i.ref_cnt > n, 1);
    order(32'h5);
    check("sref", sdram_mem_model_i.sref_q, 1);
    rd(sdram_host_pkg::REG_CTRL);
    check("status sref", got[2], 1);
    order(32'h6);
    check("sref exit", sdram_mem_model_i.sref_q, 0);
    order(32'h7);
    check("burst stop", sdram_mem_model_i.stop_cnt, 1);
    check("order faults", sdram_mem_model_i.bad_cnt, 0);
    $display("command done");
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule : sdram_command_interface_tb
bind sdram_host_ctrl sdram_host_ctrl_monitor sdram_host_ctrl_monitor_i (.clk, .reset,
  .clock_gate, .select_n, .row_strobe_n, .col_strobe_n, .write_strobe_n, .byte_mask, .dq_oe_n);

/* File: verification/sdram_host_ctrl_monitor.sv */
// Pin-level assertions for the memory command controller.
`timescale 1ns/100ps
module sdram_host_ctrl_monitor (
  input wire logic clk, // Clock.
  input wire logic reset, // Reset.
  input wire logic clock_gate, // Clock enable pin.
  input wire logic select_n, // Select pin.
  input wire logic row_strobe_n, // Row strobe pin.
  input wire logic col_strobe_n, // Column strobe pin.
  input wire logic write_strobe_n, // Write strobe pin.
  input wire logic [3:0] byte_mask, // Byte mask pins.
  input wire logic dq_oe_n // Data drive enable.
);
  logic [3:0] cmd;
  assign cmd = {select_n, row_strobe_n, col_strobe_n, write_strobe_n};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_cmd_one_cycle: assert property (!select_n |=> select_n)
    else $error("command held");
  a_gate_low_entry: assert property ($fell(clock_gate) |-> cmd == sdram_host_pkg::CMD_REFRESH)
    else $error("gate fell without refresh");
  a_sref_quiet: assert property (!clock_gate && !$past(clock_gate) |-> select_n)
    else $error("command during self refresh");
  a_drive_on_write: assert property ((cmd == sdram_host_pkg::CMD_WRITE) == !dq_oe_n)
    else $error("data drive not with write");
  a_mode_gap: assert property (cmd == sdram_host_pkg::CMD_MODE_LOAD |=>
    cmd != sdram_host_pkg::CMD_ACTIVATE && cmd != sdram_host_pkg::CMD_REFRESH)
    else $error("mode load gap short");
  a_reset_idle: assert property ($fell(reset) |->
    select_n && clock_gate && dq_oe_n && byte_mask == 4'hf) else $error("not idle after reset");
  a_act_then_rw: assert property (cmd == sdram_host_pkg::CMD_ACTIVATE |->
    ##[3:6] (cmd == sdram_host_pkg::CMD_READ || cmd == sdram_host_pkg::CMD_WRITE))
    else $error("activate without access");
  a_access_gate_high: assert property (cmd == sdram_host_pkg::CMD_ACTIVATE ||
    cmd == sdram_host_pkg::CMD_READ || cmd == sdram_host_pkg::CMD_WRITE |-> clock_gate)
    else $error("access with gate low");
endmodule : sdram_host_ctrl_monitor

/* File: verification/sdram_mem_model.sv */
// Behavioural four-bank memory that answers the controller's pins.
`timescale 1ns/100ps
module sdram_mem_model (
  input wire logic clk, // Clock.
  input wire logic clock_gate, // Clock enable.
  input wire logic select_n, // Select.
  input wire logic row_strobe_n, // Row strobe.
  input wire logic col_strobe_n, // Column strobe.
  input wire logic write_strobe_n, // Write strobe.
  input wire logic bank_select_low, // Bank bit 0.
  input wire logic bank_select_high, // Bank bit 1.
  input wire logic [11:0] mem_addr, // Address.
  input wire logic [3:0] byte_mask, // Byte mask.
  input wire logic [31:0] dq_in, // Data wire level.
  output logic [31:0] dq // Read data.
);
  logic [31:0] mem [logic [20:0]];
  logic [10:0] row_q [4];
  logic [3:0] open_q = 4'h0;
  logic [11:0] mode_q = 12'h000;
  logic sref_q = 1'b0;
  logic [32:0] rp [3] = '{3{33'h0}};
  logic [3:0] m1 = 4'hf;
  logic [31:0] dq_mem = 32'h0;
  logic [31:0] w;
  logic [1:0] b;
  logic [20:0] k;
  int ref_cnt = 0;
  int stop_cnt = 0;
  int bad_cnt = 0;
  int gap = 9;
  assign dq = dq_mem;
  assign b = {bank_select_high, bank_select_low};
  assign k = {b, row_q[b], mem_addr[7:0]};
  always @(posedge clk) begin
    rp <= '{rp[1], rp[2], 33'h0};
    m1 <= byte_mask;
    gap <= gap + 1;
    for (int i = 0; i < 4; i++) begin
      dq_mem[8*i+:8] <= rp[1][32] && !m1[i] ? rp[1][8*i+:8] : ~dq_mem[8*i+:8];
    end
    w = mem.exists(k) ? mem[k] : 32'h0;
    if (sref_q) sref_q <= !clock_gate;
    else if (!select_n) begin
      case ({1'b0, row_strobe_n, col_strobe_n, write_strobe_n})
        sdram_host_pkg::CMD_ACTIVATE: begin
          bad_cnt += (gap == 0);
          open_q[b] <= 1'b1;
          row_q[b] <= mem_addr[10:0];
        end
        sdram_host_pkg::CMD_READ, sdram_host_pkg::CMD_WRITE: begin
          bad_cnt += (!open_q[b] || ref_cnt < 2);
          open_q[b] <= open_q[b] && !mem_addr[10];
          if (write_strobe_n) rp[2] <= {1'b1, w};
          else begin
            for (int i = 0; i < 4; i++) if (!byte_mask[i]) w[8*i+:8] = dq_in[8*i+:8];
            mem[k] = w;
          end
        end
        sdram_host_pkg::CMD_BURST_STOP: stop_cnt++;
        sdram_host_pkg::CMD_PRECHARGE: open_q <= mem_addr[10] ? 4'h0 : open_q & ~(4'h1 << b);
        sdram_host_pkg::CMD_REFRESH: begin
          bad_cnt += (gap == 0);
          ref_cnt += clock_gate;
          sref_q <= !clock_gate;
        end
        sdram_host_pkg::CMD_MODE_LOAD: begin
          mode_q <= mem_addr;
          gap <= 0;
        end
        default: ;
      endcase
    end
  end
endmodule : sdram_mem_model
